// File: src/hbs_pkg.sv
// Shared constants and types of the holding brake sequencer
package hbs_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ENTRY_COUNT  = 8'h00;
  localparam logic [7:0] IDX_ENGAGE_MS    = 8'h01;
  localparam logic [7:0] IDX_CUR_OFF_MS   = 8'h02;
  localparam logic [7:0] IDX_RELEASE_MS   = 8'h03;
  localparam logic [7:0] IDX_RUN_MS       = 8'h04;
  localparam logic [7:0] IDX_PWM_HZ       = 8'h05;
  localparam logic [7:0] IDX_PWM_PERCENT  = 8'h06;
  localparam logic [7:0] IDX_STATUS       = 8'h07;

  // ----------------------------------------------------------------
  // Values after reset and limits of the settings
  // ----------------------------------------------------------------
  localparam logic [7:0]  ENTRY_COUNT_VAL = 8'h06;
  localparam logic [31:0] RST_ENGAGE_MS   = 32'h0000_03E8;
  localparam logic [31:0] RST_CUR_OFF_MS  = 32'h0000_03E8;
  localparam logic [31:0] RST_RELEASE_MS  = 32'h0000_03E8;
  localparam logic [31:0] RST_RUN_MS      = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_HZ      = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_PERCENT = 32'h0000_0000;
  localparam logic [31:0] PWM_HZ_MAX      = 32'h0000_07D0;
  localparam logic [31:0] PERCENT_MIN     = 32'h0000_0002;
  localparam logic [31:0] PERCENT_MAX     = 32'h0000_0064;

  // ----------------------------------------------------------------
  // Timing: one millisecond tick from the 250 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_PS       = 1_000_000_000;
  localparam int TICK_CYCLES   = TICK_PS / CLK_PERIOD_PS;
  localparam int CLK_HZ        = 1_000_000_000 / (CLK_PERIOD_PS / 1000);
  localparam int TICK_W        = 18;

  // Phase accumulator wraps at one second's count of clock cycles, so once per PWM period; duty step is 1 % of it
  localparam logic [27:0] PHASE_WRAP = 28'(CLK_HZ);
  localparam logic [27:0] DUTY_STEP  = 28'(CLK_HZ / 100);

  // Sequencer states, Gray coded along power up and power down except the last step, HBS_SHUT_WAIT to HBS_OFF
  typedef enum logic [2:0] {
    HBS_OFF        = 3'h0,
    HBS_REL_WAIT   = 3'h1,
    HBS_START_WAIT = 3'h3,
    HBS_RUN        = 3'h2,
    HBS_STOP_WAIT  = 3'h6,
    HBS_ENG_WAIT   = 3'h7,
    HBS_SHUT_WAIT  = 3'h5
  } hbs_state_t;

endpackage

// File: src/hbs_delay.sv
// Millisecond delay counter with its own restartable tick
`timescale 1ns/1ps
`default_nettype none
module hbs_delay #(
  parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [31:0] load_ms,
  output logic             done
);
  import hbs_pkg::*;

  typedef struct packed {
    logic [31:0]       cnt;
    logic [TICK_W-1:0] tick;
    logic              armed;
  } hbs_dly_t;

  hbs_dly_t st_reg;
  hbs_dly_t st_next;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  // Tick restarts on load so a delay of N lasts exactly N ms
  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next.cnt   = load_ms;
      st_next.tick  = '0;
      st_next.armed = 1'b1;
    end else if (st_reg.armed && st_reg.cnt != 32'h0000_0000) begin
      if (st_reg.tick == TICK_W'(TICK_CYCLES - 1)) begin
        st_next.tick = '0;
        st_next.cnt  = st_reg.cnt - 32'h0000_0001;
      end else begin
        st_next.tick = st_reg.tick + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Masked in the start cycle so a stale finish is never seen
  assign done = st_reg.armed && st_reg.cnt == 32'h0000_0000 && !start;

  a_zero_delay_done: assert property (@(posedge clk) disable iff (!nrst)
    start && load_ms == 32'h0000_0000 |=> done)
    else $error("zero delay did not finish at once");

  a_count_on_tick: assert property (@(posedge clk) disable iff (!nrst)
    !$past(start) && st_reg.cnt != $past(st_reg.cnt)
      |-> $past(st_reg.tick) == TICK_W'(TICK_CYCLES - 1)
          && st_reg.cnt == $past(st_reg.cnt) - 32'h0000_0001)
    else $error("delay counter moved off the millisecond tick");

endmodule
`default_nettype wire

// File: src/hbs_top.sv
// Holding brake sequencer: delays, brake PWM drive and register port
//
// Behaviour
// - All sequencer delays count whole milliseconds and the brake drive is a PWM of set rate and duty.
// - After the motor stands still the brake closes only once the engage delay has passed, 1000 ms at reset.
// - After the brake closes motor current goes off only once the shutdown delay has passed, 1000 ms at reset.
// - On power up current comes on first, then after the release delay (1000 ms at reset) the brake opens.
// - After the brake opens the running state is signalled only once the start delay has passed, 0 at reset.
// - The PWM rate is in hertz, only 0 through 2000 is accepted, and it resets to 0.
// - The PWM duty is in percent, only 0 or 2 through 100 is accepted, and it resets to 0.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hbs_top #(
  parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        drive_enable_req,
  input  wire logic        motor_standstill,
  output logic             motor_current_on,
  output logic             brake_release,
  output logic             brake_drive,
  output logic             drive_running
);
  import hbs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] engage_ms;
    logic [31:0] cur_off_ms;
    logic [31:0] release_ms;
    logic [31:0] run_ms;
    logic [31:0] pwm_hz;
    logic [31:0] pwm_percent;
    logic [31:0] rdata;
    hbs_state_t  fsm;
    logic        dly_start;
    logic [31:0] dly_load;
    logic [27:0] phase;
    logic        drive;
  } hbs_top_t;

  hbs_top_t st_reg;
  hbs_top_t st_next;

  logic        dly_done;
  logic [31:0] status_word;
  logic [27:0] phase_sum;
  logic [27:0] duty_thresh;
  logic        pwm_level;

  // ----------------------------------------------------------------
  // Delay counter, one shared by all four waits
  // ----------------------------------------------------------------
  // Only one wait is ever open at a time, so one counter suffices
  hbs_delay #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_delay (
    .clk     (clk),
    .nrst    (nrst),
    .start   (st_reg.dly_start),
    .load_ms (st_reg.dly_load),
    .done    (dly_done)
  );

  // ----------------------------------------------------------------
  // PWM phase and threshold
  // ----------------------------------------------------------------
  // Accumulator adds the rate each cycle and wraps at one second,
  // so no divider is needed; the rate is at most 2000 Hz
  always_comb begin
    phase_sum = st_reg.phase + st_reg.pwm_hz[27:0];
    if (phase_sum >= PHASE_WRAP) begin
      phase_sum = phase_sum - PHASE_WRAP;
    end
    duty_thresh = 28'(st_reg.pwm_percent[6:0] * DUTY_STEP);
    // Zero rate or zero duty gives a steady drive while released
    if (st_reg.pwm_hz == RST_PWM_HZ || st_reg.pwm_percent == RST_PWM_PERCENT) begin
      pwm_level = 1'b1;
    end else begin
      pwm_level = st_reg.phase < duty_thresh;
    end
  end

  // Status word seen by software
  assign status_word = {25'h000_0000, st_reg.fsm, drive_running, brake_release,
                        motor_current_on, st_reg.drive};

  // ----------------------------------------------------------------
  // Next state: registers, sequencer, read data
  // ----------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.dly_start = 1'b0;
    st_next.phase     = phase_sum;

    // Register writes; out of range settings are refused whole
    if (reg_wr) begin
      unique case (reg_addr)
        IDX_ENGAGE_MS: begin
          st_next.engage_ms = reg_wdata;
        end
        IDX_CUR_OFF_MS: begin
          st_next.cur_off_ms = reg_wdata;
        end
        IDX_RELEASE_MS: begin
          st_next.release_ms = reg_wdata;
        end
        IDX_RUN_MS: begin
          st_next.run_ms = reg_wdata;
        end
        IDX_PWM_HZ: begin
          if (reg_wdata <= PWM_HZ_MAX) begin
            st_next.pwm_hz = reg_wdata;
          end
        end
        IDX_PWM_PERCENT: begin
          if (reg_wdata == RST_PWM_PERCENT ||
              (reg_wdata >= PERCENT_MIN && reg_wdata <= PERCENT_MAX)) begin
            st_next.pwm_percent = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Read data stands only in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        IDX_ENTRY_COUNT: st_next.rdata = {24'h00_0000, ENTRY_COUNT_VAL};
        IDX_ENGAGE_MS:   st_next.rdata = st_reg.engage_ms;
        IDX_CUR_OFF_MS:  st_next.rdata = st_reg.cur_off_ms;
        IDX_RELEASE_MS:  st_next.rdata = st_reg.release_ms;
        IDX_RUN_MS:      st_next.rdata = st_reg.run_ms;
        IDX_PWM_HZ:      st_next.rdata = st_reg.pwm_hz;
        IDX_PWM_PERCENT: st_next.rdata = st_reg.pwm_percent;
        IDX_STATUS:      st_next.rdata = status_word;
        default:         st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Sequencer; each timed wait loads its delay as it is entered; HBS_STOP_WAIT loads none.
    // A delay value is latched at entry, so later writes apply next time.
    unique case (st_reg.fsm)
      HBS_OFF: begin
        if (drive_enable_req) begin
          st_next.fsm       = HBS_REL_WAIT;
          st_next.dly_start = 1'b1;
          st_next.dly_load  = st_reg.release_ms;
        end
      end
      HBS_REL_WAIT: begin
        // Brake never opened yet, so dropping out is safe at once
        if (!drive_enable_req) begin
          st_next.fsm = HBS_OFF;
        end else if (dly_done) begin
          st_next.fsm       = HBS_START_WAIT;
          st_next.dly_start = 1'b1;
          st_next.dly_load  = st_reg.run_ms;
        end
      end
      HBS_START_WAIT: begin
        if (!drive_enable_req) begin
          st_next.fsm = HBS_STOP_WAIT;
        end else if (dly_done) begin
          st_next.fsm = HBS_RUN;
        end
      end
      HBS_RUN: begin
        if (!drive_enable_req) begin
          st_next.fsm = HBS_STOP_WAIT;
        end
      end
      HBS_STOP_WAIT: begin
        // Power down runs to the end even if enable returns
        if (motor_standstill) begin
          st_next.fsm       = HBS_ENG_WAIT;
          st_next.dly_start = 1'b1;
          st_next.dly_load  = st_reg.engage_ms;
        end
      end
      HBS_ENG_WAIT: begin
        if (dly_done) begin
          st_next.fsm       = HBS_SHUT_WAIT;
          st_next.dly_start = 1'b1;
          st_next.dly_load  = st_reg.cur_off_ms;
        end
      end
      HBS_SHUT_WAIT: begin
        if (dly_done) begin
          st_next.fsm = HBS_OFF;
        end
      end
      default: begin
        st_next.fsm = HBS_OFF;
      end
    endcase

    // Brake coil is driven only while the brake is to be open
    st_next.drive = (st_next.fsm == HBS_START_WAIT || st_next.fsm == HBS_RUN ||
                     st_next.fsm == HBS_STOP_WAIT || st_next.fsm == HBS_ENG_WAIT)
                    && pwm_level;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg             <= '0;
      st_reg.engage_ms   <= RST_ENGAGE_MS;
      st_reg.cur_off_ms  <= RST_CUR_OFF_MS;
      st_reg.release_ms  <= RST_RELEASE_MS;
      st_reg.run_ms      <= RST_RUN_MS;
      st_reg.pwm_hz      <= RST_PWM_HZ;
      st_reg.pwm_percent <= RST_PWM_PERCENT;
      st_reg.fsm         <= HBS_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all decoded from registered state
  // ----------------------------------------------------------------
  assign reg_rdata        = st_reg.rdata;
  assign motor_current_on = st_reg.fsm != HBS_OFF;
  assign brake_release    = st_reg.fsm == HBS_START_WAIT || st_reg.fsm == HBS_RUN ||
                            st_reg.fsm == HBS_STOP_WAIT || st_reg.fsm == HBS_ENG_WAIT;
  assign drive_running    = st_reg.fsm == HBS_RUN;
  assign brake_drive      = st_reg.drive;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pwm_hz_range: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.pwm_hz <= PWM_HZ_MAX)
    and (reg_wr && reg_addr == IDX_PWM_HZ && reg_wdata > PWM_HZ_MAX
        |=> $stable(st_reg.pwm_hz)))
    else $error("brake PWM rate outside 0..2000");

  a_duty_range: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.pwm_percent == 32'h0000_0000
    || (st_reg.pwm_percent >= PERCENT_MIN && st_reg.pwm_percent <= PERCENT_MAX))
    else $error("brake PWM duty not 0 or 2..100");

  a_duty_one_refused: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == IDX_PWM_PERCENT && reg_wdata == 32'h0000_0001
      |=> st_reg.pwm_percent == $past(st_reg.pwm_percent))
    else $error("duty of one percent was taken");

  a_release_after_cur: assert property (@(posedge clk) disable iff (!nrst)
    $rose(brake_release) |-> motor_current_on && $past(motor_current_on)
      && $past(st_reg.fsm) == HBS_REL_WAIT && $past(dly_done))
    else $error("brake opened without current and release delay");

  a_engage_after_wait: assert property (@(posedge clk) disable iff (!nrst)
    $fell(brake_release) |-> $past(st_reg.fsm) == HBS_ENG_WAIT && $past(dly_done)
      && motor_current_on)
    else $error("brake closed before engage delay ended");

  a_current_off_last: assert property (@(posedge clk) disable iff (!nrst)
    $fell(motor_current_on) && $past(st_reg.fsm) != HBS_REL_WAIT
      |-> !brake_release && $past(!brake_release) && $past(dly_done))
    else $error("current cut before brake closed and delay ended");

  a_run_after_start: assert property (@(posedge clk) disable iff (!nrst)
    $rose(drive_running) |-> $past(st_reg.fsm) == HBS_START_WAIT && $past(dly_done)
      && brake_release)
    else $error("running signalled before start delay ended");

  a_brake_idle_off: assert property (@(posedge clk) disable iff (!nrst)
    !brake_release |-> !brake_drive)
    else $error("brake driven while it should be closed");

  a_entry_count_read: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == IDX_ENTRY_COUNT |=> reg_rdata == 32'h0000_0006)
    else $error("entry count read wrong");

  a_zero_delay_wait: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.dly_start && st_reg.dly_load == 32'h0000_0000 && st_reg.fsm == HBS_ENG_WAIT
      |-> ##2 st_reg.fsm == HBS_SHUT_WAIT)
    else $error("zero engage delay did not advance at once");

  // Legal settings land in the cycle after their write
  a_rate_write_lands: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == IDX_PWM_HZ && reg_wdata <= PWM_HZ_MAX
      |=> st_reg.pwm_hz == $past(reg_wdata))
    else $error("legal brake PWM rate not taken");

  a_duty_write_lands: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == IDX_PWM_PERCENT && (reg_wdata == 32'h0000_0000
      || (reg_wdata >= PERCENT_MIN && reg_wdata <= PERCENT_MAX))
      |=> st_reg.pwm_percent == $past(reg_wdata))
    else $error("legal brake PWM duty not taken");

  a_duty_high_refused: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == IDX_PWM_PERCENT && reg_wdata > PERCENT_MAX
      |=> $stable(st_reg.pwm_percent))
    else $error("duty above 100 percent was taken");

  // Full duty must never chop the coil, whatever the phase
  a_full_duty_steady: assert property (@(posedge clk) disable iff (!nrst)
    brake_release && $past(st_reg.pwm_percent) == PERCENT_MAX |-> brake_drive)
    else $error("coil chopped at full duty");

  // ----------------------------------------------------------------
  // Checks on the power stage and brake outputs
  // ----------------------------------------------------------------
  // An open brake always has current behind it, so the load stays held
  a_current_under_brake: assert property (@(posedge clk) disable iff (!nrst)
    brake_release |-> motor_current_on)
    else $error("brake open without motor current");

  a_running_needs_open: assert property (@(posedge clk) disable iff (!nrst)
    drive_running |-> brake_release && motor_current_on)
    else $error("running signalled with brake closed");

  // Enable low leaves running at the next edge, then waits for standstill
  a_stop_on_disable: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.fsm == HBS_RUN || st_reg.fsm == HBS_START_WAIT) && !drive_enable_req
      |=> st_reg.fsm == HBS_STOP_WAIT && !drive_running)
    else $error("running not left when enable dropped");

  a_engage_load: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.fsm == HBS_STOP_WAIT && motor_standstill
      |=> st_reg.fsm == HBS_ENG_WAIT && st_reg.dly_start
          && st_reg.dly_load == $past(st_reg.engage_ms))
    else $error("engage delay not loaded at standstill");

endmodule
`default_nettype wire

// File: test/hbs_motor_model.sv
// Behavioural motor and holding brake on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module hbs_motor_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       motor_current_on,
  input  wire logic       brake_release,
  input  wire logic       drive_running,
  input  wire logic [7:0] stop_cyc,
  output logic            motor_standstill,
  output logic            fault
);
  logic [7:0] coast_reg;
  logic       rel_reg;

  // Shaft turns while running, then coasts stop_cyc cycles (0 = prompt)
  always @(posedge clk) begin
    rel_reg <= brake_release;
    if (!nrst) begin
      motor_standstill <= 1'b1;
      coast_reg        <= 8'h00;
    end else if (drive_running) begin
      motor_standstill <= 1'b0;
      coast_reg        <= stop_cyc;
    end else if (coast_reg != 8'h00) begin
      coast_reg <= coast_reg - 8'h01;
    end else begin
      motor_standstill <= 1'b1;
    end
  end

  // Open brake without current drops the load; closing on a turning shaft wears it
  assign fault = (brake_release & ~motor_current_on)
               | (rel_reg & ~brake_release & ~motor_standstill)
               | (drive_running & ~brake_release);
endmodule
`default_nettype wire

// File: test/hbs_top_test.sv
// Self-checking bench of the holding brake sequencer
`timescale 1ns/1ps
`default_nettype none
module hbs_top_test;
  import hbs_pkg::*;
  localparam int TK = 8;

  logic        clk              = 1'b0;
  logic        nrst             = 1'b0;
  logic [7:0]  reg_addr         = 8'h00;
  logic [31:0] reg_wdata        = 32'h0000_0000;
  logic        reg_wr           = 1'b0;
  logic        reg_rd           = 1'b0;
  logic        drive_enable_req = 1'b0;
  logic [7:0]  stop_cyc         = 8'h00;
  logic [31:0] reg_rdata;
  logic        motor_standstill, motor_current_on, brake_release, brake_drive;
  logic        drive_running, fault;
  logic        rd_seen = 1'b0;
  logic        rel_d   = 1'b0;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          cmp_count = 0;

  always #2 clk = ~clk;

  hbs_top #(.TICK_CYCLES(TK)) dut_u (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_enable_req(drive_enable_req), .motor_standstill(motor_standstill),
    .motor_current_on(motor_current_on), .brake_release(brake_release),
    .brake_drive(brake_drive), .drive_running(drive_running));

  hbs_motor_model partner_u (
    .clk(clk), .nrst(nrst), .motor_current_on(motor_current_on),
    .brake_release(brake_release), .drive_running(drive_running),
    .stop_cyc(stop_cyc), .motor_standstill(motor_standstill), .fault(fault));

  // ------------------------------------------------------------
  // Checking helpers and register port tasks
  // ------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Every signal assigned once per edge, so strobes may run back to back
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
  endtask

  function automatic logic pick(int s);
    case (s)
      0: return motor_current_on;
      1: return brake_release;
      2: return drive_running;
      default: return motor_standstill;
    endcase
  endfunction

  // Bounded wait, counting edges until the chosen output reaches lvl
  task automatic wait_for(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic win(input int n, input int ms, input string msg);
    chk(n >= ms * TK && n <= ms * TK + 4, msg);
  endtask

  // ------------------------------------------------------------
  // Output watcher: read data against oldest note, far-side safety
  // ------------------------------------------------------------
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    rel_d   <= brake_release;
    if (rd_seen) begin
      if (exp_q.size() == 0)
        chk(1'b0, "read data without a note");
      else
        chk(reg_rdata === exp_q.pop_front(), "read data");
    end
    if (nrst) begin
      chk(fault !== 1'b1, "far side handled unsafely");
      chk(!(brake_drive !== 1'b0 && !brake_release && !rel_d), "coil driven while closed");
    end
  end

  // Hang guard, far above the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rst_tab [7];
    logic [31:0] dw [6];
    logic [31:0] de [6];
    int          rel_t [2], run_t [2], eng_t [2], off_t [2], stp [2];
    logic [31:0] v;
    int          n, hi;
    rst_tab = '{32'h0000_0006, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8,
                32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    rel_t = '{5, 1};
    run_t = '{2, 0};
    eng_t = '{3, 0};
    off_t = '{2, 0};
    stp   = '{40, 0};
    void'($urandom(32'heed1));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) rd(8'(i), rst_tab[i]);
    rd(8'h20, 32'h0000_0000);
    wr(8'h00, 32'h0000_00FF);
    rd(8'h00, 32'h0000_0006);
    wr(8'h05, 32'h0000_07D0);
    rd(8'h05, 32'h0000_07D0);
    wr(8'h05, 32'h0000_07D1);
    rd(8'h05, 32'h0000_07D0);
    v = $urandom_range(2000, 0);
    wr(8'h05, v);
    wr(8'h05, 32'h0000_07D1 + $urandom_range(65535, 0));
    rd(8'h05, v);
    // Duty writes: legal ones land, 1 and above 100 leave the old value
    v = $urandom_range(100, 2);
    dw = '{32'h0000_0002, 32'h0000_0001, 32'h0000_0064, 32'h0000_0065, 32'h0000_0000, v};
    de = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0064, 32'h0000_0064, 32'h0000_0000, v};
    for (int i = 0; i < 6; i++) begin
      wr(8'h06, dw[i]);
      rd(8'h06, de[i]);
    end
    wr(8'h06, 32'h0000_0000);
    wr(8'h05, 32'h0000_0000);
    // Full power up and power down, slow coast with delays, prompt coast with zeros except a 1 ms release delay
    for (int k = 0; k < 2; k++) begin
      wr(8'h01, 32'(eng_t[k]));
      wr(8'h02, 32'(off_t[k]));
      wr(8'h03, 32'(rel_t[k]));
      wr(8'h04, 32'(run_t[k]));
      stop_cyc         <= 8'(stp[k]);
      drive_enable_req <= 1'b1;
      bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
      wait_for(0, 1'b1, n);
      chk(n <= 4, "current on late");
      wait_for(1, 1'b1, n);
      win(n, rel_t[k], "brake release delay");
      wait_for(2, 1'b1, n);
      win(n, run_t[k], "start delay");
      if (k == 0) begin
        rd(8'h07, 32'h0000_002F);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
        hi = 0;
        repeat (50) begin
          @(posedge clk);
          if (brake_drive === 1'b1) hi++;
        end
        chk(hi == 50, "coil not steady with no PWM");
        wr(8'h05, 32'h0000_07D0);
        wr(8'h06, 32'h0000_0002);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
        repeat (8) @(posedge clk);
        hi = 0;
        repeat (3000) begin
          @(posedge clk);
          if (brake_drive === 1'b1) hi++;
        end
        chk(hi >= 2400 && hi <= 2600, "2 percent duty off");
        wr(8'h06, 32'h0000_0064);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
        repeat (8) @(posedge clk);
        hi = 0;
        repeat (200) begin
          @(posedge clk);
          if (brake_drive === 1'b1) hi++;
        end
        chk(hi == 200, "full duty not steady");
        wr(8'h06, 32'h0000_0000);
        wr(8'h05, 32'h0000_0000);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
      end
      drive_enable_req <= 1'b0;
      wait_for(2, 1'b0, n);
      chk(n <= 4, "running not left");
      wait_for(3, 1'b1, n);
      wait_for(1, 1'b0, n);
      win(n, eng_t[k], "engage delay");
      wait_for(0, 1'b0, n);
      win(n, off_t[k], "shutdown delay");
    end
    // Enable dropped inside the release wait: current off, brake never opened
    drive_enable_req <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    wait_for(0, 1'b1, n);
    drive_enable_req <= 1'b0;
    wait_for(0, 1'b0, n);
    chk(n <= 4 && brake_release === 1'b0, "release wait not left");
    repeat (4) @(posedge clk);
    chk(exp_q.size() == 0, "reads left unanswered");
    stop_test();
  end
endmodule
`default_nettype wire
